//--- src/panel_led_and_simulation.sv
/*
  Front-panel indicators, simulation control and wrap override.
  Assumes a classic Wishbone master, a 100 MHz clock, and that
  internal output signals, link status and sensor presence arrive
  synchronous to clk_i.
*/
// Register access over Wishbone and the address map are this design's own decisions.
`timescale 1ns/1ps
module panel_led_and_simulation #(
  parameter int unsigned BLINK_CYCLES = panel_pkg::BLINK_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Internal status inputs
  input wire logic [7:0] out_signals_i,
  input wire logic link_error_i,
  input wire logic sensor_present_i,
  input wire panel_pkg::wrap_cfg_t sensor_wrap_i,
  // Indicators and motor control
  output panel_pkg::led_pair_t comm_status_indicator_o,
  output panel_pkg::led_pair_t power_alarm_indicator_o,
  input wire logic alarm_i,
  output logic dynamic_brake_o,
  output logic brake_release_o,
  output logic sim_active_o,
  output panel_pkg::wrap_cfg_t wrap_cfg_o,
  output logic sensor_sourced_o
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
    logic [7:0] ctrl;
    logic [7:0] green_sel;
    logic [7:0] red_sel;
    logic user_wrap_en;
    logic [31:0] user_range;
    logic [31:0] user_zero;
    logic [15:0] user_ratio;
    logic [15:0] user_value;
    logic [31:0] cpos;
    logic [31:0] fpos;
    panel_pkg::led_pair_t comm_led;
    panel_pkg::led_pair_t pwr_led;
    logic dyn_brake;
    logic brake_rel;
    logic sim_act;
    panel_pkg::wrap_cfg_t wrap;
    logic sens_src;
  } panel_state_t;

  panel_state_t state;
  panel_state_t next_state;
  panel_pkg::led_pair_t blink_led;
  logic sim_run;

  // ****************************************
  // Helpers
  // ****************************************
  // Decode one internal output signal by its catalogue code
  function automatic logic pick_signal(input logic [7:0] code, input logic [7:0] sigs);
    logic r;
    r = 1'b0;
    if (code >= panel_pkg::SIG_CONST_OFF && code < panel_pkg::SIG_COUNT) begin
      r = sigs[3'(code - panel_pkg::SIG_CONST_OFF)];
    end
    if (code == panel_pkg::SIG_CONST_OFF) begin
      r = 1'b0;
    end
    return r;
  endfunction

  // Byte-lane merge for register writes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction

  assign sim_run = state.ctrl[panel_pkg::CTRL_SIM_LSB +: 2] != panel_pkg::SIM_OFF;

  // Power/alarm indicator sequencer
  sim_blinker #(
    .PHASE_CYCLES(BLINK_CYCLES)
  ) u_blink (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .run_i(sim_run),
    .led_o(blink_led)
  );

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    logic [1:0] mode;
    logic [1:0] sim;
    logic g_sig;
    logic r_sig;
    logic wr;
    logic [31:0] wv;
    logic signed [31:0] step;
    mode = state.ctrl[panel_pkg::CTRL_MODE_LSB +: 2];
    sim = state.ctrl[panel_pkg::CTRL_SIM_LSB +: 2];
    g_sig = 1'b0;
    r_sig = 1'b0;
    wr = 1'b0;
    wv = 32'h0;
    step = 32'sh0;
    next_state = state;

    // Wishbone: one-cycle ack, dropped the cycle after
    next_state.ack = cyc_i && stb_i && !state.ack;
    next_state.rdata = 32'h0;
    if (cyc_i && stb_i && !state.ack) begin
      wr = we_i;
      case (adr_i)
        panel_pkg::ADDR_CTRL: begin
          wv = merge({24'h0, state.ctrl}, dat_i, sel_i);
          if (wr) begin
            next_state.ctrl = wv[7:0];
          end
          next_state.rdata = {24'h0, state.ctrl};
        end
        panel_pkg::ADDR_SEL: begin
          wv = merge({16'h0, state.red_sel, state.green_sel}, dat_i, sel_i);
          if (wr) begin
            next_state.green_sel = wv[7:0];
            next_state.red_sel = wv[15:8];
          end
          next_state.rdata = {16'h0, state.red_sel, state.green_sel};
        end
        panel_pkg::ADDR_USER_WRAP: begin
          wv = merge({31'h0, state.user_wrap_en}, dat_i, sel_i);
          if (wr) begin
            next_state.user_wrap_en = wv[0];
          end
          next_state.rdata = {31'h0, state.user_wrap_en};
        end
        panel_pkg::ADDR_USER_RANGE: begin
          wv = merge(state.user_range, dat_i, sel_i);
          if (wr) begin
            next_state.user_range = wv;
          end
          next_state.rdata = state.user_range;
        end
        panel_pkg::ADDR_USER_ZERO: begin
          wv = merge(state.user_zero, dat_i, sel_i);
          if (wr) begin
            next_state.user_zero = wv;
          end
          next_state.rdata = state.user_zero;
        end
        panel_pkg::ADDR_USER_OFS: begin
          wv = merge({state.user_value, state.user_ratio}, dat_i, sel_i);
          if (wr) begin
            next_state.user_ratio = wv[15:0];
            next_state.user_value = wv[31:16];
          end
          next_state.rdata = {state.user_value, state.user_ratio};
        end
        panel_pkg::ADDR_STATUS: begin
          next_state.rdata = {24'h0, state.sens_src, state.sim_act, state.brake_rel, state.dyn_brake,
                              state.pwr_led, state.comm_led};
        end
        panel_pkg::ADDR_CPOS: begin
          next_state.rdata = state.cpos;
        end
        panel_pkg::ADDR_FPOS: begin
          next_state.rdata = state.fpos;
        end
        panel_pkg::ADDR_MOVE: begin
          // Signed step request to the virtual motor model
          if (wr && sim == panel_pkg::SIM_VIRTUAL || wr && sim == panel_pkg::SIM_VIRTUAL_WRAP) begin
            step = signed'(dat_i);
          end
        end
        default: next_state.rdata = 32'h0;
      endcase
    end

    // Virtual motor: command and feedback positions track together
    next_state.cpos = state.cpos + 32'(step);
    next_state.fpos = state.fpos + 32'(step);

    // Communication indicator source
    g_sig = pick_signal(state.green_sel, out_signals_i) ^ state.ctrl[panel_pkg::CTRL_GINV];
    r_sig = pick_signal(state.red_sel, out_signals_i) ^ state.ctrl[panel_pkg::CTRL_RINV];
    case (mode)
      panel_pkg::MODE_DARK: next_state.comm_led = '0;
      panel_pkg::MODE_MIRROR: next_state.comm_led = '{green: g_sig, red: r_sig};
      panel_pkg::MODE_LINK: begin
        if (state.ctrl[panel_pkg::CTRL_BUILTIN]) begin
          next_state.comm_led = '{green: !link_error_i, red: link_error_i};
        end else begin
          next_state.comm_led = '{green: g_sig, red: r_sig};
        end
      end
      default: next_state.comm_led = '0;
    endcase

    // Power/alarm indicator: sequence in simulation, else power/alarm
    if (sim_run) begin
      next_state.pwr_led = blink_led;
    end else begin
      next_state.pwr_led = '{green: !alarm_i, red: alarm_i};
    end

    // Motor held in dynamic brake, holding brake still switched
    next_state.sim_act = sim_run;
    next_state.dyn_brake = sim_run;
    next_state.brake_rel = state.ctrl[panel_pkg::CTRL_BRK_REL];

    // Wrap settings source
    next_state.sens_src = sensor_present_i;
    if (sensor_present_i) begin
      next_state.wrap = sensor_wrap_i;
    end else if (sim == panel_pkg::SIM_VIRTUAL_WRAP) begin
      next_state.wrap = '{enable: 1'b1, range: panel_pkg::SIM_WRAP_RANGE,
                          zero_count: panel_pkg::SIM_WRAP_ZERO,
                          ofs_ratio: panel_pkg::SIM_OFS_RATIO,
                          ofs_value: panel_pkg::SIM_OFS_VALUE};
    end else begin
      next_state.wrap = '{enable: state.user_wrap_en, range: state.user_range,
                          zero_count: state.user_zero, ofs_ratio: state.user_ratio,
                          ofs_value: state.user_value};
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= '0;
      state.ctrl <= panel_pkg::CTRL_RESET;
      state.green_sel <= panel_pkg::SIG_READY;
      state.red_sel <= panel_pkg::SIG_CONST_OFF;
    end else begin
      state <= next_state;
    end
  end

  assign dat_o = state.rdata;
  assign ack_o = state.ack;
  assign comm_status_indicator_o = state.comm_led;
  assign power_alarm_indicator_o = state.pwr_led;
  assign dynamic_brake_o = state.dyn_brake;
  assign brake_release_o = state.brake_rel;
  assign sim_active_o = state.sim_act;
  assign wrap_cfg_o = state.wrap;
  assign sensor_sourced_o = state.sens_src;

endmodule

//--- src/panel_pkg.sv
/*
  Constants and carrier types for the front-panel indicator and
  operation-simulation block.
  Assumes a single 100 MHz clock and a classic Wishbone register bus.
*/
// Function
// - Default role: link good lights green
// - Default role: link error lights red
// - Source mode: dark, mirror, or link/mirror
// - Mirror: green follows green selector, default 132
// - Mirror: red follows red selector, default 128
// - Green inversion flips green sense when 1
// - Red inversion flips red sense when 1
// - Simulation cycles power indicator four phases
// - Simulation holds motor in dynamic brake
// - Simulation still drives holding brake output
// - Sensor attached: five settings from sensor
// - No sensor: virtual wrap forces all five settings
// - Virtual wrap: enable, range 1800, zero 1800
// - Virtual wrap: offset ratio 50.0, value 0
// - Virtual motor model updates both positions
package panel_pkg;

  // ****************************************
  // Register map (byte addresses)
  // ****************************************
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_SEL = 8'h04;
  localparam logic [7:0] ADDR_USER_WRAP = 8'h08;
  localparam logic [7:0] ADDR_USER_RANGE = 8'h0c;
  localparam logic [7:0] ADDR_USER_ZERO = 8'h10;
  localparam logic [7:0] ADDR_USER_OFS = 8'h14;
  localparam logic [7:0] ADDR_STATUS = 8'h18;
  localparam logic [7:0] ADDR_CPOS = 8'h1c;
  localparam logic [7:0] ADDR_FPOS = 8'h20;
  localparam logic [7:0] ADDR_MOVE = 8'h24;

  // ****************************************
  // Field positions
  // ****************************************
  // CTRL: [1:0] source mode, [2] green inv, [3] red inv, [4] controller type,
  //       [6:5] sim mode, [7] holding brake release request
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_GINV = 2;
  localparam int CTRL_RINV = 3;
  localparam int CTRL_BUILTIN = 4;
  localparam int CTRL_SIM_LSB = 5;
  localparam int CTRL_BRK_REL = 7;
  // SEL: [7:0] green select, [15:8] red select
  localparam int SEL_RED_LSB = 8;

  // ****************************************
  // Encodings and reset values
  // ****************************************
  localparam logic [1:0] MODE_DARK = 2'h3; // Setting -1
  localparam logic [1:0] MODE_MIRROR = 2'h0;
  localparam logic [1:0] MODE_LINK = 2'h1;
  localparam logic [1:0] SIM_OFF = 2'h0;
  localparam logic [1:0] SIM_VIRTUAL = 2'h1;
  localparam logic [1:0] SIM_VIRTUAL_WRAP = 2'h2;
  localparam logic [7:0] CTRL_RESET = 8'h11;
  localparam logic [7:0] SIG_CONST_OFF = 8'h80; // Code 128
  localparam logic [7:0] SIG_READY = 8'h84; // Code 132
  localparam logic [7:0] SIG_COUNT = 8'h88; // Codes 128..135 decoded

  // Wrap values forced in the virtual wrap variant
  localparam logic [31:0] SIM_WRAP_RANGE = 32'h0000_0708; // 1800 rev
  localparam logic [31:0] SIM_WRAP_ZERO = 32'h0000_0708; // 1800
  localparam logic [15:0] SIM_OFS_RATIO = 16'h01f4; // 50.0 percent in 0.1 units
  localparam logic [15:0] SIM_OFS_VALUE = 16'h0000;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_HZ = 100_000_000;
  localparam int BLINK_MS = 500; // Length of one simulation blink phase
  localparam int BLINK_CYCLES = CLK_HZ / 1000 * BLINK_MS;

  // ****************************************
  // Carrier types
  // ****************************************
  typedef struct packed {
    logic green;
    logic red;
  } led_pair_t;

  typedef struct packed {
    logic enable;
    logic [31:0] range;
    logic [31:0] zero_count;
    logic [15:0] ofs_ratio;
    logic [15:0] ofs_value;
  } wrap_cfg_t;

endpackage

//--- src/sim_blinker.sv
/*
  Power/alarm indicator sequencer used while simulation runs.
  Assumes the package constants and a synchronous active-high reset.
*/
`timescale 1ns/1ps
module sim_blinker #(
  parameter int unsigned PHASE_CYCLES = panel_pkg::BLINK_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic run_i,
  output panel_pkg::led_pair_t led_o
);

  // ****************************************
  // Phase sequence
  // ****************************************
  typedef enum logic [3:0] {
    PH_GREEN = 4'h1,
    PH_RED = 4'h2,
    PH_BOTH = 4'h4,
    PH_OFF = 4'h8
  } phase_t;

  typedef struct packed {
    phase_t phase;
    logic [31:0] count;
    panel_pkg::led_pair_t led;
  } blink_state_t;

  blink_state_t state;
  blink_state_t next_state;

  // Next phase and lamp pattern
  always_comb begin
    next_state = state;
    if (!run_i) begin
      // Park at the last count of the off phase so the first green lasts a full phase
      next_state.phase = PH_OFF;
      next_state.count = 32'(PHASE_CYCLES - 1);
      next_state.led = '0;
    end else begin
      if (state.count >= 32'(PHASE_CYCLES - 1)) begin
        next_state.count = 32'h0;
        case (state.phase)
          PH_GREEN: next_state.phase = PH_RED;
          PH_RED: next_state.phase = PH_BOTH;
          PH_BOTH: next_state.phase = PH_OFF;
          PH_OFF: next_state.phase = PH_GREEN;
          default: next_state.phase = PH_GREEN;
        endcase
      end else begin
        next_state.count = state.count + 32'h1;
      end
      case (next_state.phase)
        PH_GREEN: next_state.led = '{green: 1'b1, red: 1'b0};
        PH_RED: next_state.led = '{green: 1'b0, red: 1'b1};
        PH_BOTH: next_state.led = '{green: 1'b1, red: 1'b1};
        default: next_state.led = '0;
      endcase
    end
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= '{phase: PH_OFF, count: 32'(PHASE_CYCLES - 1), led: '0};
    end else begin
      state <= next_state;
    end
  end

  assign led_o = state.led;

endmodule

//--- tb/panel_led_and_simulation_chk.sv
/*
  Checker for the panel indicator block, watching its top ports only.
  Assumes one clock, synchronous active-high reset and a classic Wishbone master.
*/
`timescale 1ns/1ps
module panel_led_and_simulation_chk #(
  parameter int unsigned BLINK_CYCLES = panel_pkg::BLINK_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic ack_o,
  input wire logic sensor_present_i,
  input wire panel_pkg::wrap_cfg_t sensor_wrap_i,
  input wire panel_pkg::led_pair_t power_alarm_indicator_o,
  input wire logic dynamic_brake_o,
  input wire logic sim_active_o,
  input wire panel_pkg::wrap_cfg_t wrap_cfg_o,
  input wire logic sensor_sourced_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // ****************************************
  // Helper logic
  // ****************************************
  logic [1:0] pwr;
  logic [1:0] pwr_q;
  logic [31:0] run_len;
  assign pwr = power_alarm_indicator_o;

  // Counts how many samples the power indicator has held its value
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pwr_q <= 2'h0;
      run_len <= 32'h0;
    end else begin
      pwr_q <= pwr;
      run_len <= (pwr != pwr_q) ? 32'h1 : run_len + 32'h1;
    end
  end

  // Next blink phase: green, red, both, off
  function automatic logic [1:0] nxt(input logic [1:0] p);
    case (p)
      2'h2: nxt = 2'h1;
      2'h1: nxt = 2'h3;
      2'h3: nxt = 2'h0;
      default: nxt = 2'h2;
    endcase
  endfunction

  // ****************************************
  // Assertions
  // ****************************************
  AST_ACK_NEXT: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("ack missing after request");
  AST_ACK_PULSE: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  AST_ACK_CAUSE: assert property (ack_o |-> $past(cyc_i && stb_i))
    else $error("ack without request");
  AST_SIM_BRAKE: assert property (sim_active_o |-> dynamic_brake_o)
    else $error("no dynamic brake in simulation");
  AST_BLINK_ORDER: assert property (
    sim_active_o && $past(sim_active_o, 3) && pwr != $past(pwr) |-> pwr == nxt($past(pwr)))
    else $error("blink phase out of order");
  AST_BLINK_LEN: assert property (
    sim_active_o && $past(pwr) == 2'h1 && pwr == 2'h3 |-> run_len == BLINK_CYCLES)
    else $error("blink phase length wrong");
  AST_SIM_START: assert property ($rose(sim_active_o) |-> ##[0:2] pwr == 2'h2)
    else $error("blink does not start green");
  AST_SENSOR_WRAP: assert property (
    $past(sensor_present_i) && !$past(rst_i) |-> sensor_sourced_o && wrap_cfg_o == $past(sensor_wrap_i))
    else $error("wrap not taken from sensor");

  // Main scenarios
  COV_SIM: cover property (sim_active_o && dynamic_brake_o);
  COV_BOTH: cover property (sim_active_o && pwr == 2'h3);
  COV_SENSOR: cover property (sensor_sourced_o);
endmodule

bind panel_led_and_simulation panel_led_and_simulation_chk #(.BLINK_CYCLES(BLINK_CYCLES)) chk (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o),
  .sensor_present_i(sensor_present_i), .sensor_wrap_i(sensor_wrap_i),
  .power_alarm_indicator_o(power_alarm_indicator_o), .dynamic_brake_o(dynamic_brake_o),
  .sim_active_o(sim_active_o), .wrap_cfg_o(wrap_cfg_o), .sensor_sourced_o(sensor_sourced_o));

//--- tb/panel_led_and_simulation_test.sv
/*
  Self-checking bench for the panel indicator block.
  Assumes the block answers on classic Wishbone and runs with short blink phases.
*/
`timescale 1ns/1ps
module test_panel_led_and_simulation;
  localparam int BC = 4;
  localparam logic [7:0] PAT = 8'h9c;
  logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, link_error_i, sensor_present_i, alarm_i;
  logic dynamic_brake_o, brake_release_o, sim_active_o, sensor_sourced_o, g, r;
  logic [7:0] adr_i, out_signals_i;
  logic [3:0] sel_i;
  logic [31:0] dat_i, dat_o, rd;
  logic [1:0] pv;
  panel_pkg::led_pair_t comm_status_indicator_o, power_alarm_indicator_o;
  panel_pkg::wrap_cfg_t sensor_wrap_i, wrap_cfg_o;
  int err_count, n_tests, n;

  panel_led_and_simulation #(.BLINK_CYCLES(BC)) uut (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .out_signals_i(out_signals_i),
    .link_error_i(link_error_i), .sensor_present_i(sensor_present_i), .sensor_wrap_i(sensor_wrap_i),
    .comm_status_indicator_o(comm_status_indicator_o), .power_alarm_indicator_o(power_alarm_indicator_o),
    .alarm_i(alarm_i), .dynamic_brake_o(dynamic_brake_o), .brake_release_o(brake_release_o),
    .sim_active_o(sim_active_o), .wrap_cfg_o(wrap_cfg_o), .sensor_sourced_o(sensor_sourced_o));

  // ****************************************
  // Tasks
  // ****************************************
  // Verdict and end of run
  task automatic close_out;
    if (err_count == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Compares a word
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("Error %0t: value %h expected %h", $time, got, exp);
    end
  endtask

  // Compares a wrap setting group
  task automatic chk_wrap(input panel_pkg::wrap_cfg_t exp);
    n_tests++;
    if (wrap_cfg_o !== exp) begin
      err_count++;
      $display("Error %0t: wrap %h expected %h", $time, wrap_cfg_o, exp);
    end
  endtask

  // One classic Wishbone cycle; read data lands in rd
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    n = 0;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    sel_i <= 4'hf;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 40);
    if (n >= 40)
      chk(32'h0, 32'h1);
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
  endtask

  // Lets registered outputs follow
  task automatic settle;
    repeat (3) @(posedge clk_i);
  endtask

  // ****************************************
  // Clock and watchdog
  // ****************************************
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  initial begin
    repeat (20000) @(posedge clk_i);
    err_count++;
    close_out();
  end

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    rst_i = 1'b1;
    {cyc_i, stb_i, we_i, link_error_i, sensor_present_i} = 5'h0;
    {adr_i, sel_i, dat_i, sensor_wrap_i} = '0;
    out_signals_i = 8'hb6;
    alarm_i = 1'b1;
    err_count = 0;
    n_tests = 0;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    // Reset values and an unmapped place
    wb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h11);
    wb(1'b0, 8'h04, 32'h0);
    chk(rd, 32'h8084);
    wb(1'b1, 8'hfc, 32'hffff_ffff);
    wb(1'b0, 8'hfc, 32'h0);
    chk(rd, 32'h0);
    // Link status in default role
    settle();
    chk(32'(comm_status_indicator_o), 32'h2);
    link_error_i <= 1'b1;
    settle();
    chk(32'(comm_status_indicator_o), 32'h1);
    // Dark, then pulse-input type mirrors the ready signal
    wb(1'b1, 8'h00, 32'h13);
    settle();
    chk(32'(comm_status_indicator_o), 32'h0);
    wb(1'b1, 8'h00, 32'h12);
    settle();
    chk(32'(comm_status_indicator_o), 32'h0);
    wb(1'b1, 8'h00, 32'h01);
    out_signals_i <= 8'h10;
    settle();
    chk(32'(comm_status_indicator_o), 32'h2);
    out_signals_i <= 8'hb6;
    // Mirror table over codes, range edges and inversions
    for (int i = 0; i < 9; i++) begin
      wb(1'b1, 8'h04, {16'h0, 8'(8'h87 - i), 8'(8'h80 + i)});
      g = (i > 0 && i < 8) ? out_signals_i[i % 8] : 1'b0;
      r = (i < 7) ? out_signals_i[7 - i] : 1'b0;
      for (int v = 0; v < 4; v++) begin
        wb(1'b1, 8'h00, 32'(v * 4));
        settle();
        chk(32'(comm_status_indicator_o), {30'h0, g ^ v[0], r ^ v[1]});
      end
    end
    // Status word outside simulation: both colours inverted, alarm on, no brake
    wb(1'b0, 8'h18, 32'h0);
    chk(rd, 32'h7);
    // Moves are ignored outside simulation
    wb(1'b1, 8'h24, 32'h7);
    // Simulation blink sequence
    wb(1'b1, 8'h00, 32'h31);
    n = 0;
    do begin
      pv = power_alarm_indicator_o;
      @(posedge clk_i);
      n++;
    end while (!(power_alarm_indicator_o === 2'h2 && pv !== 2'h2) && n < 30);
    for (int k = 0; k < 16; k++) begin
      chk(32'(power_alarm_indicator_o), 32'(PAT[7 - 2 * ((k / BC) % 4) -: 2]));
      @(posedge clk_i);
    end
    chk({30'h0, dynamic_brake_o, sim_active_o}, 32'h3);
    wb(1'b1, 8'h00, 32'hb1);
    settle();
    chk({30'h0, brake_release_o, dynamic_brake_o}, 32'h3);
    wb(1'b1, 8'h00, 32'h31);
    settle();
    chk(32'(brake_release_o), 32'h0);
    // Virtual motor positions
    wb(1'b1, 8'h24, 32'h5);
    wb(1'b1, 8'h24, 32'hffff_fffd);
    wb(1'b0, 8'h1c, 32'h0);
    chk(rd, 32'h2);
    wb(1'b0, 8'h20, 32'h0);
    chk(rd, 32'h2);
    // Wrap groups: user, forced, sensor
    wb(1'b1, 8'h08, 32'h1);
    wb(1'b1, 8'h0c, 32'h123);
    wb(1'b1, 8'h10, 32'h45);
    wb(1'b1, 8'h14, 32'h0007_0020);
    settle();
    chk_wrap({1'b1, 32'h123, 32'h45, 16'h20, 16'h7});
    wb(1'b1, 8'h00, 32'h51);
    settle();
    chk_wrap({1'b1, 32'h708, 32'h708, 16'h1f4, 16'h0});
    sensor_wrap_i <= {1'b0, 32'h1111, 32'h2222, 16'h33, 16'h44};
    sensor_present_i <= 1'b1;
    settle();
    chk_wrap({1'b0, 32'h1111, 32'h2222, 16'h33, 16'h44});
    chk(32'(sensor_sourced_o), 32'h1);
    close_out();
  end
endmodule
